// ---- inc/uart_pkg.sv ----
// Shared constants and types of the serial control and status block.
package uart_pkg;
	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_DATA      = 12'hf40;
	localparam logic [11:0] ADDR_STATUS0   = 12'hf41;
	localparam logic [11:0] ADDR_CONTROL0  = 12'hf42;
	localparam logic [11:0] ADDR_CONTROL1  = 12'hf43;
	localparam logic [11:0] ADDR_BAUD_HI   = 12'hf46;
	localparam logic [11:0] ADDR_BAUD_LO   = 12'hf47;
	localparam logic [11:0] ADDR_INT_STAT  = 12'hf48;
	localparam logic [11:0] ADDR_INT_CLEAR = 12'hf49;
	localparam logic [11:0] ADDR_INT_EN    = 12'hf4a;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int C0_TX_EN   = 7;
	localparam int C0_RX_EN   = 6;
	localparam int C0_FLOW    = 5;
	localparam int C0_PAR_EN  = 4;
	localparam int C0_PAR_ODD = 3;
	localparam int C0_BREAK   = 2;
	localparam int C0_TWO_STP = 1;
	localparam int C0_LOOP    = 0;
	localparam int C1_IR      = 0;
	localparam int C1_RX_QUIET = 1;
	localparam int INT_RX_DATA = 0;
	localparam int INT_RX_ERR  = 1;
	localparam int INT_TX_FREE = 2;
	localparam int INT_W       = 3;
	// ---------------------------------------------------------------
	// Reset values and timing counts
	// ---------------------------------------------------------------
	localparam logic [7:0]       CONTROL0_RST = 8'h00;
	localparam logic [7:0]       CONTROL1_RST = 8'h00;
	localparam logic [15:0]      BAUD_RST     = 16'h0001;
	localparam logic [INT_W-1:0] INT_EN_RST   = 3'h0;
	localparam logic [3:0]       OVS_MID      = 4'h7;
	localparam logic [3:0]       OVS_LAST     = 4'hf;
	localparam logic [3:0]       IR_PULSE     = 4'h3;
	localparam logic [4:0]       IR_HOLD      = 5'h10;
	localparam logic [2:0]       LAST_BIT     = 3'h7;
	// Serial frame states, Gray coded along idle-start-data-parity-stop.
	typedef enum logic [2:0] {
		SER_IDLE   = 3'b000,
		SER_START  = 3'b001,
		SER_DATA   = 3'b011,
		SER_PARITY = 3'b010,
		SER_STOP   = 3'b110
	} ser_state_e;
endpackage

// ---- design/uart_control_status.sv ----
// Serial receiver/transmitter with its control, status and interrupt registers.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module uart_control_status (
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        rxd_i,
	input  wire logic        cts_n_i,
	output logic             txd_o,
	output logic             irq_o
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0] ctl0_reg, ctl0_next, ctl1_reg, ctl1_next, rx_data_reg, rx_data_next;
	logic [15:0] baud_reg, baud_next, brg_cnt_reg, brg_cnt_next;
	logic tick_reg, tick_next, rxd_s1, rxd_s2, cts_s1, cts_s2;
	logic [4:0] ir_hold_reg, ir_hold_next;
	logic rda_reg, rda_next, pe_reg, pe_next, oe_reg, oe_next;
	logic fe_reg, fe_next, brk_reg, brk_next, irq_next;
	logic [uart_pkg::INT_W-1:0] ist_reg, ist_next, ien_reg, ien_next, ev;
	logic [7:0] rdata_next, status0;
	uart_pkg::ser_state_e rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;
	logic [3:0] rx_ovs_reg, rx_ovs_next, tx_ovs_reg, tx_ovs_next;
	logic [2:0] rx_bit_reg, rx_bit_next, tx_bit_reg, tx_bit_next;
	logic [7:0] rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next, tx_hold_reg, tx_hold_next;
	logic rx_par_reg, rx_par_next, rx_done_reg, rx_done_next;
	logic rx_pe_reg, rx_pe_next, rx_fe_reg, rx_fe_next, rx_brk_reg, rx_brk_next;
	logic tx_holding_empty_reg, tx_holding_empty_next, tx_line_reg, tx_line_next, txd_next, tx_load;
	logic tx_stop2_reg, tx_stop2_next, rx_src, line_out, rd_data, wr_data, tx_go;
	logic tx_par_reg, tx_par_next;

	assign rd_data = rd_i && (addr_i == uart_pkg::ADDR_DATA);
	assign wr_data = wr_i && (addr_i == uart_pkg::ADDR_DATA);
	assign status0 = {rda_reg, pe_reg, oe_reg, fe_reg, brk_reg, tx_holding_empty_reg,
		(tx_st_reg == uart_pkg::SER_IDLE), cts_s2};

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops each; only the second stage is read by any logic.
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
		end else begin
			rxd_s1 <= rxd_i;
			rxd_s2 <= rxd_s1;
			cts_s1 <= cts_n_i;
			cts_s2 <= cts_s1;
		end
	end

	// ---------------------------------------------------------------
	// Baud tick and infrared decoder
	// ---------------------------------------------------------------
	// One tick every divisor clocks gives sixteen ticks per bit; divisor 0 acts as 65536.
	// A count above a freshly lowered divisor ends the period at once instead of wrapping.
	always_comb begin
		tick_next    = (brg_cnt_reg >= baud_reg - 16'h0001);
		brg_cnt_next = tick_next ? 16'h0000 : brg_cnt_reg + 16'h0001;
		// An infrared pulse marks a zero bit; hold the decoded low for one bit time.
		ir_hold_next = ir_hold_reg;
		if (rxd_s2)
			ir_hold_next = uart_pkg::IR_HOLD;
		else if (tick_reg && ir_hold_reg != 5'h00)
			ir_hold_next = ir_hold_reg - 5'h01;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_reg    <= 1'b0;
			brg_cnt_reg <= 16'h0000;
			ir_hold_reg <= 5'h00;
		end else begin
			tick_reg    <= tick_next;
			brg_cnt_reg <= brg_cnt_next;
			ir_hold_reg <= ir_hold_next;
		end
	end

	// Receive source: loopback, infrared decoder or plain line.
	assign rx_src = ctl0_reg[uart_pkg::C0_LOOP] ? tx_line_reg :
		(ctl1_reg[uart_pkg::C1_IR] ? (ir_hold_reg == 5'h00) : rxd_s2);

	// ---------------------------------------------------------------
	// Receiver
	// ---------------------------------------------------------------
	// Start is checked at mid-bit, later bits sixteen ticks after that.
	always_comb begin
		rx_st_next  = rx_st_reg;
		rx_ovs_next = rx_ovs_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next  = rx_sh_reg;
		rx_par_next = rx_par_reg;
		rx_done_next = 1'b0;
		rx_pe_next  = rx_pe_reg;
		rx_fe_next  = rx_fe_reg;
		rx_brk_next = rx_brk_reg;
		if (tick_reg)
			rx_ovs_next = rx_ovs_reg + 4'h1;
		unique case (rx_st_reg)
			uart_pkg::SER_IDLE: begin
				rx_ovs_next = 4'h0;
				if (ctl0_reg[uart_pkg::C0_RX_EN] && !rx_src)
					rx_st_next = uart_pkg::SER_START;
			end
			uart_pkg::SER_START: if (tick_reg && rx_ovs_reg == uart_pkg::OVS_MID) begin
				rx_ovs_next = 4'h0;
				rx_bit_next = 3'h0;
				rx_st_next  = rx_src ? uart_pkg::SER_IDLE : uart_pkg::SER_DATA;
			end
			uart_pkg::SER_DATA: if (tick_reg && rx_ovs_reg == uart_pkg::OVS_LAST) begin
				rx_sh_next  = {rx_src, rx_sh_reg[7:1]};
				rx_bit_next = rx_bit_reg + 3'h1;
				if (rx_bit_reg == uart_pkg::LAST_BIT)
					rx_st_next = ctl0_reg[uart_pkg::C0_PAR_EN] ?
						uart_pkg::SER_PARITY : uart_pkg::SER_STOP;
			end
			uart_pkg::SER_PARITY: if (tick_reg && rx_ovs_reg == uart_pkg::OVS_LAST) begin
				rx_par_next = rx_src;
				rx_st_next  = uart_pkg::SER_STOP;
			end
			uart_pkg::SER_STOP: if (tick_reg && rx_ovs_reg == uart_pkg::OVS_LAST) begin
				rx_done_next = 1'b1;
				rx_fe_next   = !rx_src;
				rx_pe_next   = ctl0_reg[uart_pkg::C0_PAR_EN] &&
					((^rx_sh_reg ^ rx_par_reg) != ctl0_reg[uart_pkg::C0_PAR_ODD]);
				rx_brk_next  = !rx_src && rx_sh_reg == 8'h00 &&
					!(ctl0_reg[uart_pkg::C0_PAR_EN] && rx_par_reg);
				rx_st_next   = uart_pkg::SER_IDLE;
			end
			default: rx_st_next = uart_pkg::SER_IDLE;
		endcase
		if (!ctl0_reg[uart_pkg::C0_RX_EN])
			rx_st_next = uart_pkg::SER_IDLE;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_st_reg   <= uart_pkg::SER_IDLE;
			rx_ovs_reg  <= 4'h0;
			rx_bit_reg  <= 3'h0;
			rx_sh_reg   <= 8'h00;
			rx_par_reg  <= 1'b0;
			rx_done_reg <= 1'b0;
			rx_pe_reg   <= 1'b0;
			rx_fe_reg   <= 1'b0;
			rx_brk_reg  <= 1'b0;
		end else begin
			rx_st_reg   <= rx_st_next;
			rx_ovs_reg  <= rx_ovs_next;
			rx_bit_reg  <= rx_bit_next;
			rx_sh_reg   <= rx_sh_next;
			rx_par_reg  <= rx_par_next;
			rx_done_reg <= rx_done_next;
			rx_pe_reg   <= rx_pe_next;
			rx_fe_reg   <= rx_fe_next;
			rx_brk_reg  <= rx_brk_next;
		end
	end

	// ---------------------------------------------------------------
	// Transmitter
	// ---------------------------------------------------------------
	// Flow control holds a waiting byte until CTS is low.
	assign tx_go = ctl0_reg[uart_pkg::C0_TX_EN] && !tx_holding_empty_reg &&
		!(ctl0_reg[uart_pkg::C0_FLOW] && cts_s2);
	assign tx_load = (tx_st_reg == uart_pkg::SER_IDLE) && tx_go;
	assign line_out = tx_line_reg && !ctl0_reg[uart_pkg::C0_BREAK];

	always_comb begin
		tx_st_next    = tx_st_reg;
		tx_ovs_next   = tick_reg ? tx_ovs_reg + 4'h1 : tx_ovs_reg;
		tx_bit_next   = tx_bit_reg;
		tx_sh_next    = tx_sh_reg;
		tx_stop2_next = tx_stop2_reg;
		tx_par_next   = tx_par_reg;
		tx_hold_next  = tx_hold_reg;
		tx_holding_empty_next     = tx_holding_empty_reg;
		tx_line_next  = tx_line_reg;
		unique case (tx_st_reg)
			uart_pkg::SER_IDLE: begin
				tx_ovs_next  = 4'h0;
				tx_line_next = 1'b1;
				if (tx_load) begin
					tx_sh_next   = tx_hold_reg;
					tx_par_next  = tx_par_bit(tx_hold_reg);
					tx_holding_empty_next    = 1'b1;
					tx_line_next = 1'b0;
					tx_st_next   = uart_pkg::SER_START;
				end
			end
			uart_pkg::SER_START: if (tick_reg && tx_ovs_reg == uart_pkg::OVS_LAST) begin
				tx_bit_next  = 3'h0;
				tx_line_next = tx_sh_reg[0];
				tx_st_next   = uart_pkg::SER_DATA;
			end
			uart_pkg::SER_DATA: if (tick_reg && tx_ovs_reg == uart_pkg::OVS_LAST) begin
				tx_bit_next = tx_bit_reg + 3'h1;
				tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
				tx_line_next = tx_sh_reg[1];
				if (tx_bit_reg == uart_pkg::LAST_BIT) begin
					tx_stop2_next = ctl0_reg[uart_pkg::C0_TWO_STP];
					if (ctl0_reg[uart_pkg::C0_PAR_EN]) begin
						tx_line_next = tx_par_reg;
						tx_st_next   = uart_pkg::SER_PARITY;
					end else begin
						tx_line_next = 1'b1;
						tx_st_next   = uart_pkg::SER_STOP;
					end
				end
			end
			uart_pkg::SER_PARITY: if (tick_reg && tx_ovs_reg == uart_pkg::OVS_LAST) begin
				tx_line_next = 1'b1;
				tx_st_next   = uart_pkg::SER_STOP;
			end
			uart_pkg::SER_STOP: if (tick_reg && tx_ovs_reg == uart_pkg::OVS_LAST) begin
				tx_stop2_next = 1'b0;
				if (!tx_stop2_reg)
					tx_st_next = uart_pkg::SER_IDLE;
			end
			default: tx_st_next = uart_pkg::SER_IDLE;
		endcase
		// A write into the holding register always lands, even beside a load.
		if (wr_data) begin
			tx_hold_next = wdata_i;
			tx_holding_empty_next    = 1'b0;
		end
		// Infrared mode sends a 3/16-bit pulse for each zero, no light when idle.
		txd_next = ctl1_reg[uart_pkg::C1_IR] ?
			(!line_out && tx_ovs_reg < uart_pkg::IR_PULSE) : line_out;
	end

	// Parity is taken when the byte is loaded, so a new write into holding
	// during the frame cannot change the parity bit still to be sent.
	function automatic logic tx_par_bit(input logic [7:0] d);
		tx_par_bit = ^d ^ ctl0_reg[uart_pkg::C0_PAR_ODD];
	endfunction

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_st_reg    <= uart_pkg::SER_IDLE;
			tx_ovs_reg   <= 4'h0;
			tx_bit_reg   <= 3'h0;
			tx_sh_reg    <= 8'h00;
			tx_stop2_reg <= 1'b0;
			tx_par_reg   <= 1'b0;
			tx_hold_reg  <= 8'h00;
			tx_holding_empty_reg     <= 1'b1;
			tx_line_reg  <= 1'b1;
			txd_o        <= 1'b1;
		end else begin
			tx_st_reg    <= tx_st_next;
			tx_ovs_reg   <= tx_ovs_next;
			tx_bit_reg   <= tx_bit_next;
			tx_sh_reg    <= tx_sh_next;
			tx_stop2_reg <= tx_stop2_next;
			tx_par_reg   <= tx_par_next;
			tx_hold_reg  <= tx_hold_next;
			tx_holding_empty_reg     <= tx_holding_empty_next;
			tx_line_reg  <= tx_line_next;
			txd_o        <= txd_next;
		end
	end

	// ---------------------------------------------------------------
	// Registers, receive flags and interrupts
	// ---------------------------------------------------------------
	// Events are applied after clears so a new event is never lost.
	always_comb begin
		ctl0_next = ctl0_reg;
		ctl1_next = ctl1_reg;
		baud_next = baud_reg;
		ien_next  = ien_reg;
		rx_data_next = rx_data_reg;
		rda_next = rda_reg;
		pe_next  = pe_reg;
		oe_next  = oe_reg;
		fe_next  = fe_reg;
		brk_next = brk_reg;
		ist_next = ist_reg;
		// Writes are taken at any time; software keeps them to idle periods.
		if (wr_i) begin
			unique case (addr_i)
				uart_pkg::ADDR_CONTROL0:  ctl0_next = wdata_i;
				uart_pkg::ADDR_CONTROL1:  ctl1_next = wdata_i;
				uart_pkg::ADDR_BAUD_HI:   baud_next[15:8] = wdata_i;
				uart_pkg::ADDR_BAUD_LO:   baud_next[7:0] = wdata_i;
				uart_pkg::ADDR_INT_EN:    ien_next = wdata_i[uart_pkg::INT_W-1:0];
				uart_pkg::ADDR_INT_CLEAR: ist_next = ist_reg & ~wdata_i[uart_pkg::INT_W-1:0];
				default: ;
			endcase
		end
		if (rd_data) begin
			rda_next = 1'b0;
			pe_next  = 1'b0;
			fe_next  = 1'b0;
			brk_next = 1'b0;
			if (!rda_reg)
				oe_next = 1'b0;
		end
		if (rx_done_reg) begin
			rx_data_next = rx_sh_reg;
			rda_next = 1'b1;
			oe_next  = oe_next | rda_reg;
			pe_next  = pe_next | rx_pe_reg;
			fe_next  = fe_next | rx_fe_reg;
			brk_next = brk_next | rx_brk_reg;
		end
		ev = '0;
		ev[uart_pkg::INT_RX_DATA] = rx_done_reg && !ctl1_reg[uart_pkg::C1_RX_QUIET];
		ev[uart_pkg::INT_RX_ERR]  = rx_done_reg &&
			(rx_pe_reg || rx_fe_reg || rx_brk_reg || rda_reg);
		ev[uart_pkg::INT_TX_FREE] = tx_load;
		ist_next = ist_next | ev;
		irq_next = |(ist_reg & ien_reg);
		rdata_next = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				uart_pkg::ADDR_DATA:     rdata_next = rx_data_reg;
				uart_pkg::ADDR_STATUS0:  rdata_next = status0;
				uart_pkg::ADDR_CONTROL0: rdata_next = ctl0_reg;
				uart_pkg::ADDR_CONTROL1: rdata_next = ctl1_reg;
				uart_pkg::ADDR_BAUD_HI:  rdata_next = baud_reg[15:8];
				uart_pkg::ADDR_BAUD_LO:  rdata_next = baud_reg[7:0];
				uart_pkg::ADDR_INT_STAT: rdata_next = {5'h00, ist_reg};
				uart_pkg::ADDR_INT_EN:   rdata_next = {5'h00, ien_reg};
				default:                 rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl0_reg <= uart_pkg::CONTROL0_RST;
			ctl1_reg <= uart_pkg::CONTROL1_RST;
			baud_reg <= uart_pkg::BAUD_RST;
			ien_reg  <= uart_pkg::INT_EN_RST;
			ist_reg  <= '0;
			rx_data_reg <= 8'h00;
			rda_reg <= 1'b0;
			pe_reg  <= 1'b0;
			oe_reg  <= 1'b0;
			fe_reg  <= 1'b0;
			brk_reg <= 1'b0;
			irq_o   <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			ctl0_reg <= ctl0_next;
			ctl1_reg <= ctl1_next;
			baud_reg <= baud_next;
			ien_reg  <= ien_next;
			ist_reg  <= ist_next;
			rx_data_reg <= rx_data_next;
			rda_reg <= rda_next;
			pe_reg  <= pe_next;
			oe_reg  <= oe_next;
			fe_reg  <= fe_next;
			brk_reg <= brk_next;
			irq_o   <= irq_next;
			rdata_o <= rdata_next;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	chk_tx_start_gate: assert property (
		tx_st_reg == uart_pkg::SER_START && $past(tx_st_reg) == uart_pkg::SER_IDLE
		|-> $past(ctl0_reg[7]) && !($past(ctl0_reg[5]) && $past(cts_s2)))
		else $error("transmitter started while disabled or blocked");
	chk_rx_int_quiet: assert property (
		rx_done_reg && ctl1_reg[1] && !ist_reg[0] |=> !ist_reg[0])
		else $error("received byte raised an interrupt while suppressed");
	chk_ir_idle_dark: assert property (
		ctl1_reg[uart_pkg::C1_IR] && tx_line_reg && !ctl0_reg[uart_pkg::C0_BREAK] |=> !txd_o)
		else $error("infrared output pulsed on an idle or one bit");
	chk_rda_set: assert property (
		rx_done_reg |=> rda_reg)
		else $error("data available flag not set after receive");
	chk_rda_clear: assert property (
		rd_data && !rx_done_reg |=> !rda_reg)
		else $error("data available flag not cleared by data read");
	chk_parity_flag: assert property (
		rx_done_reg && rx_pe_reg |=> pe_reg)
		else $error("parity error not flagged");
	chk_overrun_set: assert property (
		rx_done_reg && rda_reg |=> oe_reg && rda_reg)
		else $error("overrun not flagged");
	chk_overrun_keep: assert property (
		rd_data && rda_reg && oe_reg |=> oe_reg)
		else $error("overrun cleared while data was available");
	chk_stop_framing: assert property (
		rx_st_reg == uart_pkg::SER_STOP && tick_reg &&
		rx_ovs_reg == uart_pkg::OVS_LAST && !rx_src |=> rx_fe_reg ##1 fe_reg)
		else $error("low stop bit not flagged as framing error");
	chk_status_read: assert property (
		rd_i && addr_i == uart_pkg::ADDR_STATUS0 |=> rdata_o == $past(status0, 1)
		&& rdata_o[2] == $past(tx_holding_empty_reg, 1))
		else $error("status 0 read returned wrong layout");
	chk_baud_spacing: assert property (
		tick_reg && baud_reg == 16'h0002 && $stable(baud_reg)
		|=> !tick_reg ##1 tick_reg)
		else $error("baud tick spacing does not match divisor");

	cov_rx_byte: cover property (rx_done_reg && !rx_fe_reg);
	cov_overrun: cover property (rx_done_reg && rda_reg);
	cov_tx_frame: cover property (tx_st_reg == uart_pkg::SER_STOP ##1 tx_st_reg == uart_pkg::SER_IDLE);
	cov_irq: cover property ($rose(irq_o));
endmodule

// ---- tb/serial_far_end.sv ----
// Behavioural far-end serial device for the serial control and status bench.
`timescale 1ns/100ps
module serial_far_end (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o,
	output logic      cts_n_o
);
	int bit_clks = 16;
	// ------------------------------------------------------------
	// Line driving and decoding
	// ------------------------------------------------------------
	// The line idles high between frames; clear-to-send starts withheld.
	initial begin
		rxd_o   = 1'b1;
		cts_n_o = 1'b1;
	end
	// Sends one frame LSB first; par 0 none, 1 even parity, 2 wrong parity.
	task automatic send(input logic [7:0] d, input int par, input logic stop);
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (bit_clks) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			rxd_o <= d[i];
			repeat (bit_clks) @(posedge clk_i);
		end
		if (par != 0) begin
			rxd_o <= (^d) ^ (par == 2);
			repeat (bit_clks) @(posedge clk_i);
		end
		rxd_o <= stop;
		repeat (bit_clks) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (bit_clks) @(posedge clk_i);
	endtask
	// Samples each bit of one plain frame at its middle; ok tells start and stop were seen.
	// Falling edges are used so the registered line is read where it has settled.
	task automatic recv(output logic [7:0] d, output logic ok);
		int w;
		w = 0;
		d = 8'h00;
		while (txd_i !== 1'b0 && w < 4000) begin
			@(negedge clk_i);
			w++;
		end
		repeat (bit_clks / 2) @(negedge clk_i);
		ok = (txd_i === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(negedge clk_i);
			d[i] = txd_i;
		end
		repeat (bit_clks) @(negedge clk_i);
		ok = ok && (txd_i === 1'b1);
	endtask
endmodule

// ---- tb/test_uart_control_status.sv ----
// Self-checking bench of the serial control and status block.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp); end end
module test_uart_control_status;
	logic        ref_clk_i = 1'b0;
	logic        arst_n_i  = 1'b0;
	logic [11:0] addr_i    = 12'h000;
	logic [7:0]  wdata_i   = 8'h00;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [7:0]  rdata_o;
	logic        rxd_i;
	logic        cts_n_i;
	logic        txd_o;
	logic        irq_o;
	logic [7:0]  got;
	logic        ok;
	int          hi;
	int          num_errors = 0;
	int          n_tests    = 0;
	// ------------------------------------------------------------
	// Clock, design and far end
	// ------------------------------------------------------------
	// A 4 ns period gives the 250 MHz system clock.
	always #2 ref_clk_i = ~ref_clk_i;
	uart_control_status dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
		.cts_n_i(cts_n_i), .txd_o(txd_o), .irq_o(irq_o));
	serial_far_end far_u (.clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));
	// ------------------------------------------------------------
	// Bus and helper tasks
	// ------------------------------------------------------------
	// Each access leaves one idle edge behind so no strobe is assigned twice in a step.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string m);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1;
		`CHK(rdata_o, e, m)
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Turns the unit off before touching its configuration.
	task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
		wr(uart_pkg::ADDR_CONTROL0, 8'h00);
		wr(uart_pkg::ADDR_CONTROL1, c1);
		wr(uart_pkg::ADDR_CONTROL0, c0);
	endtask
	// Flags land a few clocks after the stop sample; the idle tail covers that.
	task automatic rx(input logic [7:0] d, input int par, input logic stop);
		far_u.send(d, par, stop);
		pause(4);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rchk(uart_pkg::ADDR_STATUS0, 8'h07, "status0 reset");
		rchk(uart_pkg::ADDR_CONTROL0, 8'h00, "control0 reset");
		wr(uart_pkg::ADDR_STATUS0, 8'hff);
		rchk(uart_pkg::ADDR_STATUS0, 8'h07, "status0 written");
		wr(12'hf4f, 8'hff);
		rchk(12'hf4f, 8'h00, "unmapped read");
		@(posedge ref_clk_i);
		far_u.cts_n_o <= 1'b0;
		pause(4);
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "cts level");
	endtask
	task automatic t_rx_basic();
		cfg(8'h00, 8'h00);
		wr(uart_pkg::ADDR_BAUD_LO, 8'h02);
		far_u.bit_clks = 32;
		cfg(8'h40, 8'h00);
		rx(8'ha5, 0, 1'b1);
		`CHK(irq_o, 1'b0, "irq masked")
		rchk(uart_pkg::ADDR_STATUS0, 8'h86, "byte waiting");
		wr(uart_pkg::ADDR_INT_EN, 8'h01);
		pause(3);
		`CHK(irq_o, 1'b1, "irq enabled")
		rchk(uart_pkg::ADDR_INT_STAT, 8'h01, "int status");
		rchk(uart_pkg::ADDR_DATA, 8'ha5, "rx byte at divisor 2");
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "byte taken");
		wr(uart_pkg::ADDR_INT_CLEAR, 8'h01);
		pause(3);
		`CHK(irq_o, 1'b0, "irq cleared")
		wr(uart_pkg::ADDR_INT_EN, 8'h00);
		cfg(8'h00, 8'h00);
		wr(uart_pkg::ADDR_BAUD_LO, 8'h01);
		far_u.bit_clks = 16;
	endtask
	task automatic t_errors();
		cfg(8'h40, 8'h00);
		rx(8'h11, 0, 1'b1);
		rx(8'h22, 0, 1'b1);
		rchk(uart_pkg::ADDR_STATUS0, 8'ha6, "overrun set");
		rchk(uart_pkg::ADDR_DATA, 8'h22, "newest byte");
		rchk(uart_pkg::ADDR_STATUS0, 8'h26, "overrun kept");
		rchk(uart_pkg::ADDR_DATA, 8'h22, "second read");
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "overrun cleared");
		rx(8'h3c, 0, 1'b0);
		rchk(uart_pkg::ADDR_STATUS0, 8'h96, "framing set");
		rchk(uart_pkg::ADDR_DATA, 8'h3c, "framed byte");
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "framing cleared");
		rx(8'h00, 0, 1'b0);
		rchk(uart_pkg::ADDR_STATUS0, 8'h9e, "break set");
		rchk(uart_pkg::ADDR_DATA, 8'h00, "break byte");
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "break cleared");
		cfg(8'h50, 8'h00);
		rx(8'h5a, 2, 1'b1);
		rchk(uart_pkg::ADDR_STATUS0, 8'hc6, "parity set");
		rchk(uart_pkg::ADDR_DATA, 8'h5a, "parity byte");
		rchk(uart_pkg::ADDR_STATUS0, 8'h06, "parity cleared");
		wr(uart_pkg::ADDR_INT_CLEAR, 8'h07);
	endtask
	task automatic t_suppress();
		cfg(8'h40, 8'h02);
		wr(uart_pkg::ADDR_INT_EN, 8'h03);
		rx(8'h81, 0, 1'b1);
		`CHK(irq_o, 1'b0, "byte irq suppressed")
		rchk(uart_pkg::ADDR_DATA, 8'h81, "quiet byte");
		rx(8'h3c, 0, 1'b0);
		`CHK(irq_o, 1'b1, "error irq kept")
		rchk(uart_pkg::ADDR_DATA, 8'h3c, "error byte");
		wr(uart_pkg::ADDR_INT_CLEAR, 8'h07);
		pause(3);
		`CHK(irq_o, 1'b0, "irq cleared")
		wr(uart_pkg::ADDR_INT_EN, 8'h00);
	endtask
	task automatic t_tx();
		@(posedge ref_clk_i);
		far_u.cts_n_o <= 1'b1;
		cfg(8'h00, 8'h00);
		wr(uart_pkg::ADDR_DATA, 8'h5a);
		pause(40);
		`CHK(txd_o, 1'b1, "tx disabled")
		cfg(8'ha0, 8'h00);
		pause(40);
		`CHK(txd_o, 1'b1, "held by cts")
		far_u.cts_n_o <= 1'b0;
		far_u.recv(got, ok);
		`CHK(got, 8'h5a, "tx byte")
		`CHK(ok, 1'b1, "tx framing")
	endtask
	// An all-zero byte keeps the plain line low, so any high pulse comes from the coder.
	task automatic t_infrared();
		cfg(8'h80, 8'h01);
		pause(8);
		`CHK(txd_o, 1'b0, "ir idle")
		wr(uart_pkg::ADDR_DATA, 8'h00);
		hi = 0;
		repeat (40) begin
			@(negedge ref_clk_i);
			if (txd_o === 1'b1) hi++;
		end
		`CHK((hi > 0 && hi < 16), 1'b1, "ir pulses")
		pause(200);
		cfg(8'h00, 8'h00);
	endtask
	// Loopback with odd parity and two stop bits; the byte must come back clean.
	task automatic t_loop();
		cfg(8'hdb, 8'h00);
		wr(uart_pkg::ADDR_DATA, 8'h96);
		pause(220);
		rchk(uart_pkg::ADDR_STATUS0, 8'h86, "loopback parity clean");
		rchk(uart_pkg::ADDR_DATA, 8'h96, "loopback byte");
		cfg(8'h84, 8'h00);
		pause(4);
		`CHK(txd_o, 1'b0, "break level")
		cfg(8'h00, 8'h00);
	endtask
	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Reset is held for ten clocks, then the scenarios run in turn.
	initial begin
		repeat (10) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_rx_basic();
		t_errors();
		t_suppress();
		t_tx();
		t_infrared();
		t_loop();
		close_out();
	end
	// The scenarios need well under 6000 clocks; 20000 means a hang.
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		num_errors++;
		close_out();
	end
endmodule
